/* File: inc/hotswap_gpio_pkg.sv */
package hotswap_gpio_pkg;

    // ************************************************************
    // register offsets (byte addresses, dword aligned)
    // ************************************************************
    localparam logic [7:0] OFFS_HOT_SWAP   = 8'h74;
    localparam logic [7:0] OFFS_GENERAL_IO = 8'h78;
    localparam logic [7:0] OFFS_RSVD_7C    = 8'h7C;
    localparam logic [7:0] OFFS_PBUS_CAP   = 8'h80;

    // ************************************************************
    // constant field values
    // ************************************************************
    localparam logic [7:0] HS_CAP_ID_ON    = 8'h06;
    localparam logic [7:0] HS_CAP_ID_OFF   = 8'h00;
    localparam logic [7:0] HS_NEXT_PTR     = 8'h00;
    localparam logic [1:0] PROG_IF_CODE    = 2'h1;
    localparam logic [7:0] PBUS_CAP_ID     = 8'h07;
    localparam logic [7:0] PBUS_NEXT_PTR   = 8'h90;

    // ************************************************************
    // hot-swap field positions
    // ************************************************************
    localparam int HS_HIDE_BIT   = 16;
    localparam int HS_MASK_BIT   = 17;
    localparam int HS_PEND_BIT   = 18;
    localparam int HS_LED_BIT    = 19;
    localparam int HS_PI_LO      = 20;
    localparam int HS_EXT_BIT    = 22;
    localparam int HS_INS_BIT    = 23;

    // ************************************************************
    // general-purpose I/O field positions
    // ************************************************************
    localparam int GPIO_W        = 4;
    localparam int GPIO_OUT_CLR  = 12;
    localparam int GPIO_OUT_SET  = 16;
    localparam int GPIO_OE_CLR   = 20;
    localparam int GPIO_OE_SET   = 24;
    localparam int GPIO_IN_LO    = 28;

    // ************************************************************
    // secondary status field positions
    // ************************************************************
    localparam int SEC_WIDE_BIT   = 16;
    localparam int SEC_FAST_BIT   = 17;
    localparam int SEC_DISC_BIT   = 18;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic       INS_RESET     = 1'b1;
    localparam logic       EXT_RESET     = 1'b0;
    localparam logic [3:0] GPIO_RESET    = 4'h0;

endpackage

/* File: rtl/pin_sync3.sv */
`timescale 1ns/1ps
// three-stage synchroniser; output changes once stages two and three agree
module pin_sync3
    import hotswap_gpio_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    out_q[i] <= s3_q[i];
                end
            end
        end
    end

    assign q_o = out_q;
endmodule

/* File: rtl/hotswap_gpio_regs.sv */
`timescale 1ns/1ps
// Contract
// - hot-swap id byte reads 06h with enable strap high, else 00h
// - hot-swap next pointer reads 00h, last in chain
// - bit 16 device-hiding arm, read-write, resets to 0
// - bit 17 masks the enumeration-request output, resets to 0
// - bit 18 shows insertion armed or either flag set
// - bit 19 drives the indicator LED, resets to 0
// - bits 21:20 read constant programming interface code 01
// - bit 22 extraction flag, set on extraction request, write-1 clears
// - bit 23 insertion flag, set on insertion request, write-1 clears, resets 1
// - parallel-bus id reads 07h, next pointer 90h
// - status bit 16 wide support: forward mode and wide strap
// - status bit 17 fast capable in forward mode only
// - status bit 18 set on discarded completion, write-1 clears, resets 0
// - discarded bit held 0 and read-only in reverse mode
module hotswap_gpio_regs
    import hotswap_gpio_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        NRST_I,
    input  wire logic        CFG_RD_I,
    input  wire logic        CFG_WR_I,
    input  wire logic [7:0]  CFG_ADDR_I,
    input  wire logic [3:0]  CFG_BE_I,
    input  wire logic [31:0] CFG_WDATA_I,
    output logic      [31:0] CFG_RDATA_O,
    output logic             CFG_RVALID_O,
    input  wire logic        HOT_SWAP_ENABLE_STRAP_I,
    input  wire logic        WIDE_DEVICE_STRAP_I,
    input  wire logic        REVERSE_MODE_I,
    input  wire logic        INSERT_EVENT_I,
    input  wire logic        EXTRACT_EVENT_I,
    input  wire logic        INSERT_ARMED_I,
    input  wire logic        SPLIT_DISCARD_I,
    input  wire logic [3:0]  GPIO_PIN_I,
    output logic      [3:0]  GPIO_OUT_O,
    output logic      [3:0]  GPIO_OE_N_O,
    output logic             ENUM_REQ_N_O,
    output logic             LED_ON_O,
    output logic             DEVICE_HIDE_O
);

    // ************************************************************
    // decode
    // ************************************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] offs);
        hit = (a[7:2] == offs[7:2]);
    endfunction

    logic        wr_hs;
    logic        wr_io;
    logic        wr_sec;
    logic [3:0]  gpio_in;
    logic        hot_swap_enable_strap_q;
    logic        wide_q;
    logic        rev_q;
    logic        hide_q;
    logic        mask_q;
    logic        led_q;
    logic        ins_q;
    logic        ext_q;
    logic        disc_q;
    logic [3:0]  out_q;
    logic [3:0]  oe_n_q;
    logic [31:0] rdata_q;
    logic        rvalid_q;
    logic        enum_n_q;
    logic [31:0] hs_word;
    logic [31:0] io_word;
    logic [31:0] sec_word;
    logic [31:0] rd_d;

    assign wr_hs  = CFG_WR_I && hit(CFG_ADDR_I, OFFS_HOT_SWAP);
    assign wr_io  = CFG_WR_I && hit(CFG_ADDR_I, OFFS_GENERAL_IO);
    assign wr_sec = CFG_WR_I && hit(CFG_ADDR_I, OFFS_PBUS_CAP);

    pin_sync3 #(.W(GPIO_W)) u_gpio_sync (
        .clk_i  (CLK_I),
        .nrst_i (NRST_I),
        .d_i    (GPIO_PIN_I),
        .q_o    (gpio_in)
    );

    // ************************************************************
    // straps and mode, taken by a clocked process so reset stays constant
    // ************************************************************
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            hot_swap_enable_strap_q <= 1'b0;
            wide_q  <= 1'b0;
            rev_q   <= 1'b0;
        end else begin
            hot_swap_enable_strap_q <= HOT_SWAP_ENABLE_STRAP_I;
            wide_q  <= WIDE_DEVICE_STRAP_I;
            rev_q   <= REVERSE_MODE_I;
        end
    end

    // ************************************************************
    // hot-swap controls
    // ************************************************************
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            hide_q <= 1'b0;
            mask_q <= 1'b0;
            led_q  <= 1'b0;
        end else if (wr_hs && CFG_BE_I[2]) begin
            hide_q <= CFG_WDATA_I[HS_HIDE_BIT];
            mask_q <= CFG_WDATA_I[HS_MASK_BIT];
            led_q  <= CFG_WDATA_I[HS_LED_BIT];
        end
    end

    // flags: a new event wins over a write-1 clear in the same cycle
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            ins_q <= INS_RESET;
            ext_q <= EXT_RESET;
        end else begin
            if (INSERT_EVENT_I) begin
                ins_q <= 1'b1;
            end else if (wr_hs && CFG_BE_I[2] && CFG_WDATA_I[HS_INS_BIT]) begin
                ins_q <= 1'b0;
            end
            if (EXTRACT_EVENT_I) begin
                ext_q <= 1'b1;
            end else if (wr_hs && CFG_BE_I[2] && CFG_WDATA_I[HS_EXT_BIT]) begin
                ext_q <= 1'b0;
            end
        end
    end

    // active-low request; mask keeps it from asserting
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            enum_n_q <= 1'b1;
        end else begin
            enum_n_q <= ~((ins_q | ext_q) & ~mask_q);
        end
    end

    // ************************************************************
    // secondary status
    // ************************************************************
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            disc_q <= 1'b0;
        end else if (rev_q) begin
            disc_q <= 1'b0;
        end else if (SPLIT_DISCARD_I) begin
            disc_q <= 1'b1;
        end else if (wr_sec && CFG_BE_I[2] && CFG_WDATA_I[SEC_DISC_BIT]) begin
            disc_q <= 1'b0;
        end
    end

    // ************************************************************
    // general-purpose I/O
    // ************************************************************
    generate
        for (genvar g = 0; g < GPIO_W; g++) begin : g_io
            always_ff @(posedge CLK_I) begin
                if (!NRST_I) begin
                    out_q[g] <= GPIO_RESET[g];
                    oe_n_q[g] <= ~GPIO_RESET[g];
                end else if (wr_io) begin
                    if (CFG_BE_I[2] && CFG_WDATA_I[GPIO_OUT_SET+g]) begin
                        out_q[g] <= 1'b1;
                    end else if (CFG_BE_I[1] && CFG_WDATA_I[GPIO_OUT_CLR+g]) begin
                        out_q[g] <= 1'b0;
                    end
                    if (CFG_BE_I[3] && CFG_WDATA_I[GPIO_OE_SET+g]) begin
                        oe_n_q[g] <= 1'b0;
                    end else if (CFG_BE_I[2] && CFG_WDATA_I[GPIO_OE_CLR+g]) begin
                        oe_n_q[g] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // read path
    // ************************************************************
    always_comb begin
        hs_word = '0;
        hs_word[7:0]  = hot_swap_enable_strap_q ? HS_CAP_ID_ON : HS_CAP_ID_OFF;
        hs_word[15:8] = HS_NEXT_PTR;
        hs_word[HS_HIDE_BIT] = hide_q;
        hs_word[HS_MASK_BIT] = mask_q;
        hs_word[HS_PEND_BIT] = INSERT_ARMED_I | ins_q | ext_q;
        hs_word[HS_LED_BIT]  = led_q;
        hs_word[HS_PI_LO+1:HS_PI_LO] = PROG_IF_CODE;
        hs_word[HS_EXT_BIT] = ext_q;
        hs_word[HS_INS_BIT] = ins_q;
    end

    always_comb begin
        io_word = '0;
        io_word[GPIO_IN_LO+GPIO_W-1:GPIO_IN_LO] = gpio_in;
    end

    always_comb begin
        sec_word = '0;
        sec_word[7:0]  = PBUS_CAP_ID;
        sec_word[15:8] = PBUS_NEXT_PTR;
        sec_word[SEC_WIDE_BIT] = ~rev_q & wide_q;
        sec_word[SEC_FAST_BIT] = ~rev_q;
        sec_word[SEC_DISC_BIT] = disc_q;
    end

    always_comb begin
        rd_d = '0;
        if (hit(CFG_ADDR_I, OFFS_HOT_SWAP)) begin
            rd_d = hs_word;
        end else if (hit(CFG_ADDR_I, OFFS_GENERAL_IO)) begin
            rd_d = io_word;
        end else if (hit(CFG_ADDR_I, OFFS_PBUS_CAP)) begin
            rd_d = sec_word;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            rdata_q  <= '0;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= CFG_RD_I;
            if (CFG_RD_I) begin
                rdata_q <= rd_d;
            end
        end
    end

    assign CFG_RDATA_O   = rdata_q;
    assign CFG_RVALID_O  = rvalid_q;
    assign GPIO_OUT_O    = out_q;
    // enables are kept inverted so the pin comes straight from a flop
    assign GPIO_OE_N_O   = oe_n_q;
    assign ENUM_REQ_N_O  = enum_n_q;
    assign LED_ON_O      = led_q;
    assign DEVICE_HIDE_O = hide_q;

endmodule

/* File: verif/hotswap_gpio_monitor.sv */
`timescale 1ns/1ps
module hotswap_gpio_monitor
    import hotswap_gpio_pkg::*;
(
    input wire logic        CLK_I,
    input wire logic        NRST_I,
    input wire logic        CFG_RD_I,
    input wire logic        CFG_WR_I,
    input wire logic [7:0]  CFG_ADDR_I,
    input wire logic [3:0]  CFG_BE_I,
    input wire logic [31:0] CFG_WDATA_I,
    input wire logic [31:0] CFG_RDATA_O,
    input wire logic        CFG_RVALID_O,
    input wire logic        HOT_SWAP_ENABLE_STRAP_I,
    input wire logic        WIDE_DEVICE_STRAP_I,
    input wire logic        REVERSE_MODE_I,
    input wire logic        INSERT_ARMED_I,
    input wire logic [3:0]  GPIO_OUT_O,
    input wire logic [3:0]  GPIO_OE_N_O,
    input wire logic        LED_ON_O,
    input wire logic        DEVICE_HIDE_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    // straps and mode pass one flop, so reads see them two edges back
    wire logic [5:0] ra = CFG_ADDR_I[7:2];
    wire logic hs_wr = CFG_WR_I && ra == OFFS_HOT_SWAP[7:2] && CFG_BE_I[2];
    wire logic io_wr = CFG_WR_I && ra == OFFS_GENERAL_IO[7:2];
    wire logic rd_hs = CFG_RD_I && ra == OFFS_HOT_SWAP[7:2];
    wire logic rd_pb = CFG_RD_I && ra == OFFS_PBUS_CAP[7:2];
    wire logic rd_7c = CFG_RD_I && ra == OFFS_RSVD_7C[7:2];
    wire logic led_bit = CFG_WDATA_I[HS_LED_BIT];
    wire logic hide_bit = CFG_WDATA_I[HS_HIDE_BIT];
    wire logic [3:0] out_set = CFG_WDATA_I[GPIO_OUT_SET +: 4];
    wire logic [3:0] oe_set = CFG_WDATA_I[GPIO_OE_SET +: 4];
    property p_rd_answer; CFG_RD_I |=> CFG_RVALID_O; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_hs_id; rd_hs |=> CFG_RDATA_O[15:0] == {HS_NEXT_PTR,
        $past(HOT_SWAP_ENABLE_STRAP_I, 2) ? HS_CAP_ID_ON : HS_CAP_ID_OFF}; endproperty
    a_hs_id: assert property (p_hs_id) else $error("hot-swap id");
    property p_hs_const;
        rd_hs |=> CFG_RDATA_O[21:20] == PROG_IF_CODE && CFG_RDATA_O[31:24] == 8'h00;
    endproperty
    a_hs_const: assert property (p_hs_const) else $error("hs constants");
    property p_pending; rd_hs |=> CFG_RDATA_O[HS_PEND_BIT] == ($past(INSERT_ARMED_I)
        | CFG_RDATA_O[HS_EXT_BIT] | CFG_RDATA_O[HS_INS_BIT]); endproperty
    a_pending: assert property (p_pending) else $error("pending bit");
    property p_led; hs_wr |=> LED_ON_O == $past(led_bit); endproperty
    a_led: assert property (p_led) else $error("led output");
    property p_hide; hs_wr |=> DEVICE_HIDE_O == $past(hide_bit); endproperty
    a_hide: assert property (p_hide) else $error("hide output");
    property p_pbus; rd_pb |=> CFG_RDATA_O[15:0] == {PBUS_NEXT_PTR, PBUS_CAP_ID}
        && CFG_RDATA_O[17:16] == ($past(REVERSE_MODE_I, 2) ? 2'b00
        : {1'b1, $past(WIDE_DEVICE_STRAP_I, 2)}); endproperty
    a_pbus: assert property (p_pbus) else $error("pbus word");
    property p_disc_rev;
        rd_pb && $past(REVERSE_MODE_I, 2) && $past(REVERSE_MODE_I) |=> !CFG_RDATA_O[SEC_DISC_BIT];
    endproperty
    a_disc_rev: assert property (p_disc_rev) else $error("discard in reverse");
    property p_rsvd; rd_7c |=> CFG_RDATA_O == 32'h0000_0000; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved word");
    property p_out_set;
        io_wr && CFG_BE_I[2] |=> (GPIO_OUT_O & $past(out_set)) == $past(out_set);
    endproperty
    a_out_set: assert property (p_out_set) else $error("gpio set");
    property p_oe_set; io_wr && CFG_BE_I[3] |=> (GPIO_OE_N_O & $past(oe_set)) == 4'h0;
    endproperty
    a_oe_set: assert property (p_oe_set) else $error("gpio enable set");
endmodule
bind hotswap_gpio_regs hotswap_gpio_monitor i_mon (.CLK_I(CLK_I), .NRST_I(NRST_I),
    .CFG_RD_I(CFG_RD_I), .CFG_WR_I(CFG_WR_I), .CFG_ADDR_I(CFG_ADDR_I), .CFG_BE_I(CFG_BE_I),
    .CFG_WDATA_I(CFG_WDATA_I), .CFG_RDATA_O(CFG_RDATA_O), .CFG_RVALID_O(CFG_RVALID_O),
    .HOT_SWAP_ENABLE_STRAP_I(HOT_SWAP_ENABLE_STRAP_I), .REVERSE_MODE_I(REVERSE_MODE_I),
    .WIDE_DEVICE_STRAP_I(WIDE_DEVICE_STRAP_I), .INSERT_ARMED_I(INSERT_ARMED_I),
    .GPIO_OUT_O(GPIO_OUT_O), .GPIO_OE_N_O(GPIO_OE_N_O), .LED_ON_O(LED_ON_O),
    .DEVICE_HIDE_O(DEVICE_HIDE_O));

/* File: verif/cfg_host.sv */
`timescale 1ns/1ps
module cfg_host (
    input  wire logic        clk_i,
    input  wire logic [31:0] rdata_i,
    input  wire logic        rvalid_i,
    output logic             rd_o,
    output logic             wr_o,
    output logic      [7:0]  addr_o,
    output logic      [3:0]  be_o,
    output logic      [31:0] wdata_o
);
    initial begin
        {rd_o, wr_o, addr_o, be_o, wdata_o} = '0;
    end
    // released data is inverted so a stale value never looks valid
    task automatic cfg_wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        @(posedge clk_i);
        #1 {wr_o, addr_o, be_o, wdata_o} = {1'b1, a, b, d};
        @(posedge clk_i);
        #1 {wr_o, wdata_o} = {1'b0, ~d};
    endtask
    task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d, output logic ok);
        @(posedge clk_i);
        #1 {rd_o, addr_o} = {1'b1, a};
        @(posedge clk_i);
        #1 rd_o = 1'b0;
        ok = rvalid_i;
        d = rdata_i;
    endtask
endmodule

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb
    import hotswap_gpio_pkg::*;
;
    logic clk, nrst, hot_swap_enable_strap, wide, rev, insertion_flag, extraction_flag, armed, disc, ok;
    logic [3:0] pins, gout, goe_n;
    logic rd, wr, rvalid, enum_n, led, hide;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata, rdata, d;
    int err_count, tests_run;
    cfg_host host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .rd_o(rd), .wr_o(wr),
        .addr_o(addr), .be_o(be), .wdata_o(wdata));
    hotswap_gpio_regs i_hotswap_gpio_regs (.CLK_I(clk), .NRST_I(nrst), .CFG_RD_I(rd),
        .CFG_WR_I(wr), .CFG_ADDR_I(addr), .CFG_BE_I(be), .CFG_WDATA_I(wdata),
        .CFG_RDATA_O(rdata), .CFG_RVALID_O(rvalid), .HOT_SWAP_ENABLE_STRAP_I(hot_swap_enable_strap),
        .WIDE_DEVICE_STRAP_I(wide), .REVERSE_MODE_I(rev), .INSERT_EVENT_I(insertion_flag),
        .EXTRACT_EVENT_I(extraction_flag), .INSERT_ARMED_I(armed), .SPLIT_DISCARD_I(disc),
        .GPIO_PIN_I(pins), .GPIO_OUT_O(gout), .GPIO_OE_N_O(goe_n), .ENUM_REQ_N_O(enum_n),
        .LED_ON_O(led), .DEVICE_HIDE_O(hide));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        host.cfg_rd(a, d, ok);
        chk("rvalid", 32'h1, {31'h0, ok});
        chk(n, e, d);
    endtask
    task automatic pulse(ref logic s);
        @(posedge clk);
        #1 s = 1'b1;
        @(posedge clk);
        #1 s = 1'b0;
    endtask
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task t_reset_vals;
        rdchk("hs reset", OFFS_HOT_SWAP, 32'h0094_0006);
        chk("enum", 32'h0, {31'h0, enum_n});
        chk("outs", 32'h3C, {22'h0, gout, goe_n, led, hide});
    endtask
    task t_hot_swap;
        host.cfg_wr(OFFS_HOT_SWAP, 4'h4, 32'h008B_0000);
        rdchk("hs set", OFFS_HOT_SWAP, 32'h001B_0006);
        chk("led hide enum", 32'h7, {29'h0, led, hide, enum_n});
        pulse(insertion_flag);
        rdchk("ins masked", OFFS_HOT_SWAP, 32'h009F_0006);
        chk("enum masked", 32'h1, {31'h0, enum_n});
        host.cfg_wr(OFFS_HOT_SWAP, 4'h4, 32'h0009_0000);
        settle();
        chk("enum unmasked", 32'h0, {31'h0, enum_n});
        pulse(extraction_flag);
        rdchk("ext", OFFS_HOT_SWAP, 32'h00DD_0006);
        host.cfg_wr(OFFS_HOT_SWAP, 4'h4, 32'h00C9_0000);
        settle();
        rdchk("flags clr", OFFS_HOT_SWAP, 32'h0019_0006);
        chk("enum idle", 32'h1, {31'h0, enum_n});
        armed = 1'b1;
        rdchk("armed", OFFS_HOT_SWAP, 32'h001D_0006);
        {armed, hot_swap_enable_strap} = 2'b00;
        settle();
        rdchk("strap low", OFFS_HOT_SWAP, 32'h0019_0000);
        hot_swap_enable_strap = 1'b1;
    endtask
    task t_gpio;
        host.cfg_wr(OFFS_GENERAL_IO, 4'hC, 32'h050A_0000);
        chk("gpio set", 32'hAA, {24'h0, gout, goe_n});
        host.cfg_wr(OFFS_GENERAL_IO, 4'h6, 32'h0011_F000);
        host.cfg_wr(OFFS_GENERAL_IO, 4'hF, 32'h0000_0000);
        chk("gpio clr", 32'h1B, {24'h0, gout, goe_n});
        pins = 4'h9;
        repeat (6) @(posedge clk);
        rdchk("gpio in", OFFS_GENERAL_IO, 32'h9000_0000);
    endtask
    task t_pbus;
        rdchk("pbus fwd", OFFS_PBUS_CAP, 32'h0003_9007);
        wide = 1'b0;
        pulse(disc);
        rdchk("discard", OFFS_PBUS_CAP, 32'h0006_9007);
        host.cfg_wr(OFFS_PBUS_CAP, 4'h4, 32'h0004_0000);
        rdchk("discard clr", OFFS_PBUS_CAP, 32'h0002_9007);
        {rev, wide} = 2'b11;
        settle();
        pulse(disc);
        host.cfg_wr(OFFS_PBUS_CAP, 4'hF, 32'hFFFF_FFFF);
        rdchk("pbus rev", OFFS_PBUS_CAP, 32'h0000_9007);
        rev = 1'b0;
    endtask
    task t_rsvd;
        host.cfg_wr(OFFS_RSVD_7C, 4'hF, 32'hFFFF_FFFF);
        rdchk("rsvd 7c", OFFS_RSVD_7C, 32'h0);
        rdchk("unmapped", 8'h84, 32'h0);
        host.cfg_wr(OFFS_HOT_SWAP, 4'hB, 32'hFF00_FFFF);
        rdchk("hs ro", OFFS_HOT_SWAP, 32'h0019_0006);
        host.cfg_wr(OFFS_HOT_SWAP, 4'h4, 32'h0000_0000);
        chk("led off", 32'h0, {30'h0, led, hide});
    endtask
    task stop_test;
        $display("err_count=%0d tests_run=%0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        {nrst, insertion_flag, extraction_flag, armed, disc, rev, pins} = '0;
        {hot_swap_enable_strap, wide, err_count, tests_run} = '0;
        {hot_swap_enable_strap, wide} = 2'b11;
        repeat (10) @(posedge clk);
        #1 nrst = 1'b1;
        t_reset_vals();
        t_hot_swap();
        t_gpio();
        t_pbus();
        t_rsvd();
        stop_test();
    end
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        stop_test();
    end
endmodule
